// >>> hw/ltc_pkg.sv
// Package: register map, field positions and timing constants of the ladder timer/counter.
package ltc_pkg;

	// ****************************************************************
	// Register map (byte addresses, one aligned word each)
	// ****************************************************************
	localparam logic [7:0] LTC_CTRL_OFS = 8'h00;
	localparam logic [7:0] LTC_TMR_STAT_OFS = 8'h04;
	localparam logic [7:0] LTC_TMR_PRE_OFS = 8'h08;
	localparam logic [7:0] LTC_TMR_ACC_OFS = 8'h0c;
	localparam logic [7:0] LTC_CNT_STAT_OFS = 8'h10;
	localparam logic [7:0] LTC_CNT_PRE_OFS = 8'h14;
	localparam logic [7:0] LTC_CNT_ACC_OFS = 8'h18;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int LTC_EN_BIT = 15;
	localparam int LTC_TT_BIT = 14;
	localparam int LTC_DN_BIT = 13;
	localparam int LTC_CU_BIT = 15;
	localparam int LTC_CD_BIT = 14;
	localparam int LTC_OV_BIT = 12;
	localparam int LTC_UN_BIT = 11;
	// Control word: [0] timer rung, [1] counter rung, [2] clear, [3] run mode,
	// [5:4] time base, [7:6] timer type, [8] counter direction (1 = down).
	localparam int LTC_C_TRUNG = 0;
	localparam int LTC_C_CRUNG = 1;
	localparam int LTC_C_CLR = 2;
	localparam int LTC_C_RUN = 3;
	localparam int LTC_C_TB_LO = 4;
	localparam int LTC_C_TY_LO = 6;
	localparam int LTC_C_DOWN = 8;

	localparam logic [15:0] LTC_ZERO16 = 16'h0000;
	localparam logic [15:0] LTC_ONE16 = 16'h0001;
	localparam logic [15:0] LTC_SMAX = 16'h7fff;
	localparam logic [15:0] LTC_SMIN = 16'h8000;
	localparam logic [31:0] LTC_ZERO32 = 32'h0000_0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int LTC_CLK_HZ = 25_000_000;
	localparam int LTC_TB_1MS_US = 1000;
	localparam int LTC_TB_10MS_US = 10000;
	localparam int LTC_TB_1S_US = 1000000;
	localparam int LTC_TICK_1MS = LTC_CLK_HZ / 1000000 * LTC_TB_1MS_US;
	localparam int LTC_TICK_10MS = LTC_CLK_HZ / 1000000 * LTC_TB_10MS_US;
	localparam int LTC_TICK_1S = LTC_CLK_HZ / 1000000 * LTC_TB_1S_US;

	typedef enum logic [1:0] {
		LTC_TB_1MS = 2'h0,
		LTC_TB_10MS = 2'h1,
		LTC_TB_1S = 2'h2
	} ltc_base_type;

	typedef enum logic [1:0] {
		LTC_ON_DELAY = 2'h0,
		LTC_OFF_DELAY = 2'h1,
		LTC_RETENTIVE = 2'h3
	} ltc_kind_type;

	typedef struct packed {
		logic en;
		logic tt;
		logic dn;
	} ltc_tflags_type;

	typedef struct packed {
		logic cu;
		logic cd;
		logic dn;
		logic ov;
		logic un;
	} ltc_cflags_type;

endpackage : ltc_pkg

// >>> hw/ltc_timer_counter.sv
// Module: one timer element and one counter element behind an APB slave.
//
// Summary of operation
// - Interval ends up to one base early.
// - Gaps under 2.5 seconds lose no time.
// - On-delay counts while rung true, stops at preset.
// - On-delay accumulator clears when rung false.
// - On-delay cleared on reset and mode change.
// - On-delay flags enable, timing, done behave.
// - Off-delay counts while rung false until preset.
// - Off-delay accumulator clears when rung true.
// - Off-delay timing flag while false below preset.
// - Off-delay done clears once false at preset.
// - Off-delay cleared on reset and mode change.
// - Retentive counts while rung true until preset.
// - Retentive keeps accumulator through rung and mode; reset clears it.
// - Retentive done holds until clear command.
// - Only clear or reset empties retentive accumulator.
// - Signed counts; wrap flags; clear zeroes counter.
// - Counter status bits fifteen down to eleven.
// - Counter done when accumulator reaches preset.
// - Count once per false-to-true rung edge.
// - Counter accumulator kept until clear command.
// - Counting continues beyond the preset.
// - Timer values 0 to 32767, three bases.
// - Counter wraps max to min and back.
// - Clear zeroes accumulator and flags when active; an off-delay timer ignores it.
`timescale 1ns/1ps
`default_nettype none

module ltc_timer_counter
	import ltc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [8:0] ctrl_ff;
	logic [14:0] tmr_pre_ff;
	logic [14:0] tmr_acc_ff;
	ltc_tflags_type tflags_ff;
	logic [15:0] cnt_pre_ff;
	logic [15:0] cnt_acc_ff;
	ltc_cflags_type cflags_ff;
	logic crung_prev_ff;
	logic run_prev_ff;
	logic [24:0] div_ff;
	logic tick;

	logic wr_en;
	logic rd_en;
	logic trung;
	logic crung;
	logic clr;
	logic run;
	logic mode_chg;
	ltc_base_type base;
	ltc_kind_type kind;
	logic [24:0] div_top;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	// Only these seven words answer; anything else earns a slave error.
	function automatic logic reg_mapped(input logic [7:0] a);
		unique case (a)
			LTC_CTRL_OFS,
			LTC_TMR_STAT_OFS,
			LTC_TMR_PRE_OFS,
			LTC_TMR_ACC_OFS,
			LTC_CNT_STAT_OFS,
			LTC_CNT_PRE_OFS,
			LTC_CNT_ACC_OFS: begin
				reg_mapped = 1'b1;
			end
			default: begin
				reg_mapped = 1'b0;
			end
		endcase
	endfunction : reg_mapped

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	// Every access completes at once, so the bus never sees a wait state.
	assign pready = 1'b1;
	assign trung = ctrl_ff[LTC_C_TRUNG];
	assign crung = ctrl_ff[LTC_C_CRUNG];
	assign clr = ctrl_ff[LTC_C_CLR];
	assign run = ctrl_ff[LTC_C_RUN];
	assign base = ltc_base_type'(ctrl_ff[LTC_C_TB_LO +: 2]);
	assign kind = ltc_kind_type'(ctrl_ff[LTC_C_TY_LO +: 2]);
	// Any toggle of the run bit counts as a mode change, in either direction.
	assign mode_chg = run ^ run_prev_ff;

	// ****************************************************************
	// Time-base tick
	// ****************************************************************
	// The divider runs freely while in run mode, so the first count of a
	// newly started timer lands within one base, never later than nominal.
	// The divider is wide enough for the one-second base at this clock.
	always_comb begin
		unique case (base)
			LTC_TB_10MS: div_top = 25'(LTC_TICK_10MS - 1);
			LTC_TB_1S: div_top = 25'(LTC_TICK_1S - 1);
			default: div_top = 25'(LTC_TICK_1MS - 1);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 25'h0000000;
		end else if (!run || div_ff >= div_top) begin
			div_ff <= 25'h0000000;
		end else begin
			div_ff <= div_ff + 25'h0000001;
		end
	end

	assign tick = run && (div_ff == div_top);

	// ****************************************************************
	// Mode and rung history
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_prev_ff <= 1'b0;
		end else begin
			run_prev_ff <= run;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crung_prev_ff <= 1'b0;
		end else begin
			crung_prev_ff <= crung;
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 9'h000;
		end else if (wr_en && addr_hit(paddr, LTC_CTRL_OFS)) begin
			ctrl_ff <= pwdata[8:0];
		end
	end

	// ****************************************************************
	// Timer element
	// ****************************************************************
	// Hardware evaluates every cycle, so no elapsed time is ever lost
	// however long software leaves the rung untouched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_pre_ff <= 15'h0000;
		end else if (wr_en && addr_hit(paddr, LTC_TMR_PRE_OFS)) begin
			tmr_pre_ff <= pwdata[14:0];
		end
	end

	// Clear is ignored for an off-delay element, whose output would glitch.
	logic tmr_clr;
	logic tmr_acc_wr;
	logic tmr_mode_clr;
	logic tmr_at_pre;
	assign tmr_clr = clr && kind != LTC_OFF_DELAY && run;
	assign tmr_acc_wr = wr_en && addr_hit(paddr, LTC_TMR_ACC_OFS);
	assign tmr_mode_clr = mode_chg && kind != LTC_RETENTIVE;
	assign tmr_at_pre = tmr_acc_ff >= tmr_pre_ff;

	// A software write to the accumulator wins over a tick or a mode change in the same
	// cycle; only an active clear in that cycle discards the preload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_acc_ff <= 15'h0000;
		end else if (tmr_clr) begin
			tmr_acc_ff <= 15'h0000;
		end else if (tmr_acc_wr) begin
			tmr_acc_ff <= pwdata[14:0];
		end else if (tmr_mode_clr) begin
			tmr_acc_ff <= 15'h0000;
		end else if (run) begin
			unique case (kind)
				LTC_OFF_DELAY: begin
					if (trung) begin
						tmr_acc_ff <= 15'h0000;
					end else if (tick && tflags_ff.dn && !tmr_at_pre) begin
						tmr_acc_ff <= tmr_acc_ff + 15'h0001;
					end
				end
				LTC_RETENTIVE: begin
					if (tick && trung && !tmr_at_pre) begin
						tmr_acc_ff <= tmr_acc_ff + 15'h0001;
					end
				end
				default: begin
					if (!trung) begin
						tmr_acc_ff <= 15'h0000;
					end else if (tick && !tmr_at_pre) begin
						tmr_acc_ff <= tmr_acc_ff + 15'h0001;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Timer flags
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tflags_ff <= '0;
		end else if (tmr_clr) begin
			tflags_ff <= '0;
		end else if (tmr_acc_wr) begin
			tflags_ff <= tflags_ff;
		end else if (tmr_mode_clr) begin
			tflags_ff <= '0;
		end else if (!run) begin
			tflags_ff.tt <= 1'b0;
		end else begin
			unique case (kind)
				LTC_OFF_DELAY: begin
					tflags_ff.en <= trung;
					if (trung) begin
						tflags_ff.dn <= 1'b1;
						tflags_ff.tt <= 1'b0;
					end else if (tmr_at_pre) begin
						tflags_ff.dn <= 1'b0;
						tflags_ff.tt <= 1'b0;
					end else begin
						tflags_ff.tt <= tflags_ff.dn;
					end
				end
				LTC_RETENTIVE: begin
					tflags_ff.en <= trung;
					if (tmr_at_pre) begin
						tflags_ff.dn <= 1'b1;
						tflags_ff.tt <= 1'b0;
					end else begin
						tflags_ff.tt <= trung;
					end
				end
				default: begin
					tflags_ff.en <= trung;
					if (!trung) begin
						tflags_ff <= '0;
					end else if (tmr_at_pre) begin
						tflags_ff.dn <= 1'b1;
						tflags_ff.tt <= 1'b0;
					end else begin
						tflags_ff.tt <= 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Counter element
	// ****************************************************************
	logic cnt_edge;
	logic [15:0] cnt_next;
	// Edges are taken only in run mode; a rung toggled while stopped is lost.
	assign cnt_edge = run && crung && !crung_prev_ff;
	assign cnt_next = ctrl_ff[LTC_C_DOWN] ? cnt_acc_ff - LTC_ONE16 : cnt_acc_ff + LTC_ONE16;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_pre_ff <= LTC_ZERO16;
		end else if (wr_en && addr_hit(paddr, LTC_CNT_PRE_OFS)) begin
			cnt_pre_ff <= pwdata[15:0];
		end
	end

	// The counter is not touched by mode changes; only a clear empties it.
	logic cnt_acc_wr;
	logic cnt_clr;
	logic cnt_wrap_up;
	logic cnt_wrap_down;
	assign cnt_acc_wr = wr_en && addr_hit(paddr, LTC_CNT_ACC_OFS);
	assign cnt_clr = clr && run;
	assign cnt_wrap_up = cnt_edge && !cnt_acc_wr && !ctrl_ff[LTC_C_DOWN]
		&& cnt_acc_ff == LTC_SMAX;
	assign cnt_wrap_down = cnt_edge && !cnt_acc_wr && ctrl_ff[LTC_C_DOWN]
		&& cnt_acc_ff == LTC_SMIN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_acc_ff <= LTC_ZERO16;
		end else if (cnt_clr) begin
			cnt_acc_ff <= LTC_ZERO16;
		end else if (cnt_acc_wr) begin
			cnt_acc_ff <= pwdata[15:0];
		end else if (cnt_edge) begin
			cnt_acc_ff <= cnt_next;
		end
	end

	// ****************************************************************
	// Counter flags
	// ****************************************************************
	// Clear is a level command, so it wins over a wrap in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cflags_ff <= '0;
		end else if (cnt_clr) begin
			cflags_ff <= '0;
		end else begin
			if (cnt_wrap_up) begin
				cflags_ff.ov <= 1'b1;
			end
			if (cnt_wrap_down) begin
				cflags_ff.un <= 1'b1;
			end
			cflags_ff.cu <= run && crung && !ctrl_ff[LTC_C_DOWN];
			cflags_ff.cd <= run && crung && ctrl_ff[LTC_C_DOWN];
			cflags_ff.dn <= $signed(cnt_acc_ff) >= $signed(cnt_pre_ff);
		end
	end

	// ****************************************************************
	// APB read path
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= LTC_ZERO32;
		end else if (psel && !penable && !pwrite) begin
			// Loaded in the setup cycle, the word stands through the access phase.
			unique case (paddr)
				LTC_CTRL_OFS: prdata <= {23'h000000, ctrl_ff};
				LTC_TMR_STAT_OFS: prdata <= {16'h0000, tflags_ff, 13'h0000};
				LTC_TMR_PRE_OFS: prdata <= {17'h00000, tmr_pre_ff};
				LTC_TMR_ACC_OFS: prdata <= {17'h00000, tmr_acc_ff};
				LTC_CNT_STAT_OFS: prdata <= {16'h0000, cflags_ff, 11'h000};
				LTC_CNT_PRE_OFS: prdata <= {16'h0000, cnt_pre_ff};
				LTC_CNT_ACC_OFS: prdata <= {16'h0000, cnt_acc_ff};
				default: prdata <= LTC_ZERO32;
			endcase
		end
	end

	assign pslverr = (wr_en || rd_en) && !reg_mapped(paddr);

endmodule : ltc_timer_counter

`default_nettype wire

// >>> test/ltc_monitor.sv
// Checker of the APB ports of the ladder timer/counter.
`timescale 1ns/1ps
`default_nettype none
module ltc_monitor
	import ltc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ********
	// Control shadow
	// ********
	// Status lags a control write, so reads are judged only once it has settled.
	logic [15:0] c_ff;
	logic [2:0] age_ff;
	logic rd;
	assign rd = psel && penable && !pwrite && age_ff > 3'h2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_ff <= 16'h0000;
			age_ff <= 3'h0;
		end else if (psel && penable && pwrite && paddr == LTC_CTRL_OFS) begin
			c_ff <= pwdata[15:0];
			age_ff <= 3'h0;
		end else if (age_ff != 3'h7) begin
			age_ff <= age_ff + 3'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********
	// Properties
	// ********
	property p_err;
		psel && penable |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0);
	endproperty
	a_err: assert property (p_err) else $error("slave error wrong");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
	property p_on_idle;
		rd && paddr == LTC_TMR_STAT_OFS && c_ff[7:6] == 2'h0 && !c_ff[0] |-> prdata == 32'h0;
	endproperty
	a_on_idle: assert property (p_on_idle) else $error("idle timer flags set");
	property p_on_acc;
		rd && paddr == LTC_TMR_ACC_OFS && c_ff[7:6] == 2'h0 && !c_ff[0] |-> prdata == 32'h0;
	endproperty
	a_on_acc: assert property (p_on_acc) else $error("idle timer count kept");
	property p_off_true;
		rd && paddr == LTC_TMR_STAT_OFS && c_ff[7:6] == 2'h1 && c_ff[0] && c_ff[3]
			|-> prdata == 32'ha000;
	endproperty
	a_off_true: assert property (p_off_true) else $error("off timer flags wrong");
	property p_off_acc;
		rd && paddr == LTC_TMR_ACC_OFS && c_ff[7:6] == 2'h1 && c_ff[0] |-> prdata == 32'h0;
	endproperty
	a_off_acc: assert property (p_off_acc) else $error("off timer count kept");
	property p_cnt_stat;
		rd && paddr == LTC_CNT_STAT_OFS |-> prdata[31:16] == 16'h0 && prdata[10:0] == 11'h0;
	endproperty
	a_cnt_stat: assert property (p_cnt_stat) else $error("unused status bits set");
	property p_cnt_en;
		rd && paddr == LTC_CNT_STAT_OFS && c_ff[3] && !c_ff[2]
			|-> prdata[15:14] == {c_ff[1] && !c_ff[8], c_ff[1] && c_ff[8]};
	endproperty
	a_cnt_en: assert property (p_cnt_en) else $error("count enables wrong");
	property p_clr;
		rd && paddr == LTC_CNT_ACC_OFS && c_ff[2] && c_ff[3] |-> prdata == 32'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left a count");
endmodule : ltc_monitor
bind ltc_timer_counter ltc_monitor ltc_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> test/ltc_tb.sv
// Self-checking bench of the ladder timer/counter.
`timescale 1ns/1ps
`default_nettype none
module tb
	import ltc_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, err;
	int mismatches = 0, n_checks = 0, cyc = 0;
	int cacc, cpre, ov, un, t0;
	ltc_timer_counter ltc_timer_counter_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial begin
		forever #20 pclk = ~pclk;
	end
	// The gap before each setup lets the status words settle after a control write.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		repeat (3) @(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rdchk
	task automatic waitdn();
		t0 = cyc;
		do xfer(1'b0, LTC_TMR_STAT_OFS, 32'h0);
		while (rdata[13] !== 1'b1 && cyc - t0 < 26000);
		chk(32'(cyc - t0 <= 25015), 32'h1);
	endtask : waitdn
	function automatic logic [31:0] cst();
		return {16'h0, 2'h0, cacc >= cpre, 1'(ov), 1'(un), 11'h0};
	endfunction : cst
	task automatic pulse(input logic dn);
		xfer(1'b1, LTC_CTRL_OFS, {23'h0, dn, 8'h4b});
		cacc = dn ? cacc - 1 : cacc + 1;
		if (cacc > 32767) begin
			cacc = -32768;
			ov = 1;
		end
		if (cacc < -32768) begin
			cacc = 32767;
			un = 1;
		end
		rdchk(LTC_CNT_STAT_OFS, cst() | (dn ? 32'h4000 : 32'h8000));
		xfer(1'b1, LTC_CTRL_OFS, {23'h0, dn, 8'h49});
	endtask : pulse
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(57));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b1, LTC_TMR_PRE_OFS, 32'h1);
		xfer(1'b1, LTC_CTRL_OFS, 32'h8);
		xfer(1'b1, LTC_CTRL_OFS, 32'h9);
		waitdn();
		rdchk(LTC_TMR_STAT_OFS, 32'ha000);
		rdchk(LTC_TMR_ACC_OFS, 32'h1);
		xfer(1'b1, LTC_CTRL_OFS, 32'h8);
		rdchk(LTC_TMR_STAT_OFS, 32'h0);
		rdchk(LTC_TMR_ACC_OFS, 32'h0);
		$display("on-delay done");
		xfer(1'b1, LTC_CTRL_OFS, 32'hc9);
		waitdn();
		xfer(1'b1, LTC_CTRL_OFS, 32'hc0);
		xfer(1'b1, LTC_CTRL_OFS, 32'hc8);
		rdchk(LTC_TMR_STAT_OFS, 32'h2000);
		rdchk(LTC_TMR_ACC_OFS, 32'h1);
		xfer(1'b1, LTC_CTRL_OFS, 32'hcc);
		rdchk(LTC_TMR_STAT_OFS, 32'h0);
		rdchk(LTC_TMR_ACC_OFS, 32'h0);
		$display("retentive done");
		xfer(1'b1, LTC_CTRL_OFS, 32'h49);
		rdchk(LTC_TMR_STAT_OFS, 32'ha000);
		rdchk(LTC_TMR_ACC_OFS, 32'h0);
		xfer(1'b1, LTC_CTRL_OFS, 32'h48);
		rdchk(LTC_TMR_STAT_OFS, 32'h6000);
		xfer(1'b1, LTC_CTRL_OFS, 32'h49);
		$display("off-delay done");
		cpre = int'($urandom_range(10)) - 5;
		cacc = cpre - 2;
		ov = 0;
		un = 0;
		xfer(1'b1, LTC_CNT_PRE_OFS, {16'h0, 16'(cpre)});
		xfer(1'b1, LTC_CNT_ACC_OFS, {16'h0, 16'(cacc)});
		repeat (4) pulse(1'b0);
		rdchk(LTC_CNT_STAT_OFS, cst());
		xfer(1'b1, LTC_CTRL_OFS, 32'h41);
		xfer(1'b1, LTC_CTRL_OFS, 32'h49);
		rdchk(LTC_CNT_ACC_OFS, {16'h0, 16'(cacc)});
		for (int i = 0; i < 2; i++) begin
			cacc = i ? -32768 : 32767;
			xfer(1'b1, LTC_CNT_ACC_OFS, {16'h0, 16'(cacc)});
			pulse(i[0]);
			rdchk(LTC_CNT_ACC_OFS, {16'h0, 16'(cacc)});
		end
		xfer(1'b1, LTC_CNT_STAT_OFS, 32'hffff);
		rdchk(LTC_CNT_STAT_OFS, cst());
		xfer(1'b1, LTC_CTRL_OFS, 32'h0d);
		cacc = 0;
		ov = 0;
		un = 0;
		rdchk(LTC_CNT_ACC_OFS, 32'h0);
		xfer(1'b1, LTC_CTRL_OFS, 32'h49);
		rdchk(LTC_CNT_STAT_OFS, cst());
		$display("counter done");
		complete_run();
	end
endmodule : tb
`default_nettype wire
